// [rtl/scbi_ctrl.sv]
`timescale 1ns/1ps
// controller end: APB registers, command sequencer, refresh pacing, read queue
module scbi_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  // clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory pins
  scbi_if.ctl mem
);
  import scbi_pkg::*;
  if (FIFO_DEPTH < 8 || FIFO_DEPTH > 32) begin : g_chk
    $error("scbi_ctrl: queue must hold an 8-word burst");
  end
  typedef enum logic [2:0] {S_IDLE, S_ACT, S_DATA, S_GAP, S_LOW} scbi_state_e;
  scbi_state_e state_r;
  logic [2:0] ctl_r;
  logic [ADR_W-1:0] addr_r;
  logic [MODE_W-1:0] mode_r;
  logic [DQ_W-1:0] wdata_r;
  logic [1:0] pwr_r;
  logic go_r, mrs_r, ref_r, sr_r, cke_r, dqoe_r;
  logic [REF_TMR_W-1:0] tmr_r;
  logic [2:0] cmd_r;
  logic [1:0] ba_r;
  logic [ROW_W-1:0] a_r;
  logic [DQ_W-1:0] dqo_r;
  logic [5:0] cnt_r;
  logic acc, wacc, mapped, page, take, cap, fin, fin_wr;
  logic [5:0] len, cl;
  logic f_ready, f_valid;
  logic [DQ_W-1:0] f_data;

  // apb: the freeze input stretches the access phase
  assign pready = ce;
  assign acc = psel & penable & pready;
  assign wacc = acc & pwrite;
  assign mapped = paddr inside {REG_CTRL, REG_ADDR, REG_MODE, REG_WDATA, REG_STAT, REG_RDATA, REG_PWR};
  assign pslverr = psel & penable & ~mapped;
  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      REG_CTRL: prdata[CTRL_AP:CTRL_GO] = {ctl_r[CTRL_AP:CTRL_WR], go_r};
      REG_ADDR: prdata[ADR_W-1:0] = addr_r;
      REG_MODE: prdata[MODE_W-1:0] = mode_r;
      REG_WDATA: prdata[DQ_W-1:0] = wdata_r;
      REG_STAT: prdata[STAT_LOW:STAT_BUSY] = {state_r == S_LOW, f_valid, state_r != S_IDLE || go_r};
      REG_RDATA: prdata[DQ_W-1:0] = f_data;
      REG_PWR: prdata[1:0] = pwr_r;
      default: prdata = 32'h00000000;
    endcase
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
      addr_r <= '0;
      mode_r <= MODE_RST;
      wdata_r <= '0;
      pwr_r <= '0;
    end else if (wacc) begin
      case (paddr)
        REG_CTRL: ctl_r <= pwdata[2:0];
        REG_ADDR: addr_r <= pwdata[ADR_W-1:0];
        REG_MODE: mode_r <= pwdata[MODE_W-1:0];
        REG_WDATA: wdata_r <= pwdata[DQ_W-1:0];
        REG_PWR: pwr_r <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // burst geometry from the mode word
  assign page = mode_r[MR_BL_LSB +: 3] == BL_PAGE;
  assign len = page ? 6'(FIFO_DEPTH) : 6'h01 << mode_r[MR_BL_LSB +: 2]; // [RL5]
  assign cl = 6'(mode_r[MR_CL_LSB +: 3]);
  // a read starts only into an empty queue, so software reads throttle the memory
  assign take = state_r == S_IDLE && !ref_r && !mrs_r && pwr_r == '0 && go_r &&
                (ctl_r[CTRL_WR] || (f_ready && !f_valid));
  assign cap = state_r == S_DATA && !ctl_r[CTRL_WR] && cnt_r >= cl && cnt_r < cl + len; // [RL7]
  assign fin_wr = ctl_r[CTRL_WR] && cnt_r == len;
  assign fin = fin_wr || (!ctl_r[CTRL_WR] && cnt_r == cl + len - 6'h01);

  // pending work; a new request in the cycle it is taken stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r <= 1'b0;
      mrs_r <= 1'b0;
      ref_r <= 1'b0;
      tmr_r <= '0;
    end else if (ce) begin
      go_r <= (wacc && paddr == REG_CTRL && pwdata[CTRL_GO]) || (go_r && !take);
      mrs_r <= (wacc && paddr == REG_MODE) || (mrs_r && !(state_r == S_IDLE && !ref_r));
      tmr_r <= (tmr_r == REF_TMR_W'(REF_INT_CYC - 1)) ? '0 : tmr_r + 1'b1;
      // the memory refreshes itself while in self refresh
      if (tmr_r == REF_TMR_W'(REF_INT_CYC - 1)) ref_r <= 1'b1; // [RL10]
      else if ((state_r == S_IDLE) || (state_r == S_LOW && sr_r)) ref_r <= 1'b0;
    end
  end

  // command sequencer; every op ends with all banks closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      cmd_r <= CMD_NOP;
      ba_r <= '0;
      a_r <= '0;
      cke_r <= 1'b1;
      sr_r <= 1'b0;
      dqo_r <= '0;
      dqoe_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce) begin
      case (state_r)
        S_IDLE: begin
          cmd_r <= CMD_NOP;
          if (ref_r) begin
            cmd_r <= CMD_REF; // [RL10]
            state_r <= S_GAP;
          end else if (mrs_r) begin
            cmd_r <= CMD_MRS;
            a_r <= ROW_W'(mode_r);
            state_r <= S_GAP;
          end else if (pwr_r != '0) begin
            cke_r <= 1'b0; // [RL12]
            sr_r <= pwr_r[PWR_SR];
            if (pwr_r[PWR_SR]) cmd_r <= CMD_REF;
            state_r <= S_LOW;
          end else if (take) begin
            cmd_r <= CMD_ACT; // [RL4]
            ba_r <= addr_r[ADR_BANK_LSB +: 2];
            a_r <= addr_r[ADR_ROW_LSB +: ROW_W];
            state_r <= S_ACT;
          end
        end
        S_ACT: begin
          cmd_r <= ctl_r[CTRL_WR] ? CMD_WR : CMD_RD; // [RL4]
          a_r <= ROW_W'(addr_r[ADR_COL_LSB +: COL_W]);
          a_r[AP_BIT] <= ctl_r[CTRL_AP];
          dqo_r <= wdata_r;
          dqoe_r <= ctl_r[CTRL_WR];
          cnt_r <= '0;
          state_r <= S_DATA;
        end
        S_DATA: begin
          cnt_r <= cnt_r + 1'b1;
          cmd_r <= (page && cnt_r == len - 6'h01) ? CMD_BST : CMD_NOP;
          dqo_r <= wdata_r + DQ_W'(cnt_r) + 16'h0001;
          if (cnt_r == len - 6'h01) dqoe_r <= 1'b0;
          if (fin) begin
            // a page burst never precharges itself
            if (!ctl_r[CTRL_AP] || page) begin
              cmd_r <= CMD_PRE;
              a_r[AP_BIT] <= 1'b0;
            end
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          cmd_r <= CMD_NOP;
          state_r <= S_IDLE;
        end
        S_LOW: begin
          cmd_r <= CMD_NOP;
          // power down is left early when a refresh falls due
          if (pwr_r == '0 || (ref_r && !sr_r)) begin
            cke_r <= 1'b1;
            state_r <= S_GAP;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  scbi_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) u_rdq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(cap),
    .in_data(mem.data_io_bus),
    .in_ready(f_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(acc && !pwrite && paddr == REG_RDATA)
  );

  // pins
  assign mem.cke = cke_r;
  assign mem.cs_n = 1'b0;
  assign {mem.ras_n, mem.cas_n, mem.we_n} = cmd_r;
  assign mem.bank_select_bit0 = ba_r[0];
  assign mem.bank_select_bit1 = ba_r[1];
  assign mem.addr = a_r;
  assign mem.low_byte_mask = 1'b0;
  assign mem.high_byte_mask = 1'b0;
  assign mem.ctl_dq_o = dqo_r;
  assign mem.ctl_dq_oe = dqoe_r;
endmodule // scbi_ctrl

// [rtl/scbi_device.sv]
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// memory end: command decode, open rows, burst engine, clock enable and low power
module scbi_device #(
  parameter int ROW_USED = 12,
  parameter int COL_USED = 9
) (
  // memory pins
  scbi_if.dev mem,
  // reset
  input wire logic presetn,
  // status
  output logic [scbi_pkg::BANKS-1:0] bank_open,
  output logic power_down,
  output logic self_refresh,
  output logic [15:0] refresh_count
);
  import scbi_pkg::*;
  localparam int AW = ROW_USED + COL_USED;
  // a full array is 8M words; shrink rows and columns for fast simulation
  if (ROW_USED < 1 || ROW_USED > ROW_W || COL_USED < 3 || COL_USED > COL_W) begin : g_chk
    $error("scbi_device: array size out of range");
  end

  // storage, one row-major plane per bank
  logic [DQ_W-1:0] store [BANKS][2**AW]; // [RL3]

  // captured state
  logic cke_r;
  logic pd_r;
  logic sr_r;
  logic [MODE_W-1:0] mode_r;
  logic [BANKS-1:0] open_r;
  logic [ROW_W-1:0] row_r [BANKS];
  logic burst_r;
  logic bwr_r;
  logic bap_r;
  logic [1:0] bbank_r;
  logic [COL_W-1:0] bcol_r;
  logic [COL_W-1:0] bcnt_r;
  logic [DQ_W-1:0] s1_r, s2_r, s3_r;
  logic v1_r, v2_r, v3_r;
  logic [REF_TMR_W-1:0] srt_r;
  logic [15:0] refc_r;

  // decode
  logic ien;
  logic sel;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic [1:0] bk;
  logic [1:0] dqm;
  logic is_rd;
  logic is_wr;
  logic start;
  logic stop;
  logic page;
  logic cl3;
  logic beat;
  logic last;
  logic wdir;
  logic ap_now;
  logic rd_beat;
  logic [COL_W:0] blen;
  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] idx;
  logic [COL_W-1:0] base;
  logic [COL_W-1:0] col;
  logic [AW-1:0] waddr;
  logic [DQ_W-1:0] rword;

  // the internal clock runs only when clock enable was high at the previous edge
  assign ien = cke_r & ~pd_r & ~sr_r; // [RL11] [RL14]
  // commands count only when chip select is low at the edge
  assign sel = ien & ~mem.cs_n; // [RL17] [RL1]
  assign cmd = {mem.ras_n, mem.cas_n, mem.we_n};
  assign bank = {mem.bank_select_bit1, mem.bank_select_bit0}; // [RL19] [RL15]
  assign dqm = {mem.high_byte_mask, mem.low_byte_mask};
  // a column access to a closed bank is dropped
  assign is_rd = sel && cmd == CMD_RD && open_r[bank];
  assign is_wr = sel && cmd == CMD_WR && open_r[bank];
  assign start = is_rd | is_wr;
  assign stop = sel && cmd == CMD_BST; // [RL8]
  assign page = mode_r[MR_BL_LSB +: 3] == BL_PAGE;
  assign cl3 = mode_r[MR_CL_LSB +: 3] == CL_3;

  // burst length in words; full page wraps over the whole row
  always_comb begin
    if (page) begin
      blen = (COL_W+1)'(2**COL_USED); // [RL5]
    end else begin
      blen = (COL_W+1)'(1) << mode_r[MR_BL_LSB +: 2]; // [RL5]
    end
  end
  assign mask = COL_W'(blen - 1'b1);

  // beat zero comes straight off the pins, later beats from the burst counter
  assign idx = start ? '0 : bcnt_r;
  assign base = start ? mem.addr[COL_W-1:0] : bcol_r; // [RL16]
  assign col = (base & ~mask) | ((mode_r[MR_BT_BIT] ? (base ^ idx) : (base + idx)) & mask); // [RL6]
  assign bk = start ? bank : bbank_r;
  assign waddr = {row_r[bk][ROW_USED-1:0], col[COL_USED-1:0]};
  assign wdir = start ? is_wr : bwr_r;
  assign ap_now = start ? mem.address_bit_ten_autoprecharge : bap_r; // [RL16]
  // a stop or a new column command ends the current burst at once
  assign beat = start | (burst_r & ien & ~stop);
  assign last = ~page && idx == mask;
  assign rword = store[bk][waddr];
  // a beat with both bytes masked leaves the bus undriven
  assign rd_beat = beat & ~wdir & ~&dqm;

  // clock enable itself is never frozen, or the part could not wake
  always_ff @(posedge mem.pclk or negedge presetn) begin
    if (!presetn) begin
      cke_r <= 1'b1;
    end else begin
      cke_r <= mem.cke; // [RL11]
    end
  end

  // power down and self refresh; clock enable is watched at every edge while asleep
  always_ff @(posedge mem.pclk or negedge presetn) begin
    if (!presetn) begin
      pd_r <= 1'b0;
      sr_r <= 1'b0;
    end else if (pd_r || sr_r) begin
      if (mem.cke) begin
        pd_r <= 1'b0; // [RL13]
        sr_r <= 1'b0; // [RL13]
      end
    end else if (ien && !mem.cke && open_r == '0 && !burst_r && !v1_r && !v2_r && !v3_r) begin // [RL12]
      if (sel && cmd == CMD_REF) begin
        sr_r <= 1'b1; // [RL10]
      end else if (!sel || cmd == CMD_NOP) begin
        pd_r <= 1'b1;
      end
    end
  end

  // mode word and bank open state
  always_ff @(posedge mem.pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RST;
      open_r <= '0;
    end else begin
      if (sel) begin
        case (cmd)
          CMD_MRS: begin
            if (open_r == '0) mode_r <= mem.addr[MODE_W-1:0];
          end
          CMD_ACT: begin
            open_r[bank] <= 1'b1; // [RL18] [RL15]
          end
          CMD_PRE: begin
            if (mem.address_bit_ten_autoprecharge) open_r <= '0; // [RL18]
            else open_r[bank] <= 1'b0; // [RL18] [RL15]
          end
          default: begin
          end
        endcase
      end
      // self-timed precharge once the last beat has gone
      if (beat && last && ap_now) open_r[bk] <= 1'b0; // [RL9]
    end
  end

  // row address held per bank; meaningless while the bank is closed
  always_ff @(posedge mem.pclk) begin
    if (sel && cmd == CMD_ACT) row_r[bank] <= mem.addr; // [RL16] [RL4]
  end

  // burst engine
  always_ff @(posedge mem.pclk or negedge presetn) begin
    if (!presetn) begin
      burst_r <= 1'b0;
      bwr_r <= 1'b0;
      bap_r <= 1'b0;
      bbank_r <= '0;
      bcol_r <= '0;
      bcnt_r <= '0;
    end else if (ien) begin
      if (start) begin
        burst_r <= ~last;
        bwr_r <= is_wr;
        bap_r <= mem.address_bit_ten_autoprecharge;
        bbank_r <= bank;
        bcol_r <= mem.addr[COL_W-1:0];
        bcnt_r <= COL_W'(1);
      end else if (burst_r) begin
        if (stop || last) burst_r <= 1'b0; // [RL8]
        bcnt_r <= bcnt_r + 1'b1; // [RL2]
      end
    end
  end

  // write beats, byte masks hold a byte unchanged
  always_ff @(posedge mem.pclk) begin
    if (beat && wdir) begin
      for (int b = 0; b < DQ_W / BYTE_W; b++) begin
        if (!dqm[b]) store[bk][waddr][b*BYTE_W +: BYTE_W] <= mem.data_io_bus[b*BYTE_W +: BYTE_W];
      end
    end
  end

  // read pipe: latency three enters one stage earlier than latency two
  always_ff @(posedge mem.pclk or negedge presetn) begin
    if (!presetn) begin
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      v3_r <= 1'b0;
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ien) begin
      v1_r <= rd_beat & cl3; // [RL7]
      s1_r <= rword;
      v2_r <= cl3 ? v1_r : rd_beat; // [RL7]
      s2_r <= cl3 ? s1_r : rword;
      v3_r <= v2_r; // [RL2]
      s3_r <= s2_r; // [RL2]
    end
  end

  // refresh bookkeeping; self refresh paces itself off the same interval
  always_ff @(posedge mem.pclk or negedge presetn) begin
    if (!presetn) begin
      srt_r <= '0;
      refc_r <= '0;
    end else if (sr_r) begin
      if (srt_r == REF_TMR_W'(REF_INT_CYC - 1)) begin
        srt_r <= '0;
        refc_r <= refc_r + 1'b1; // [RL10]
      end else begin
        srt_r <= srt_r + 1'b1;
      end
    end else begin
      srt_r <= '0;
      if (sel && cmd == CMD_REF && mem.cke) refc_r <= refc_r + 1'b1; // [RL10]
    end
  end

  // outputs
  assign mem.dev_dq_o = s3_r;
  assign mem.dev_dq_oe = v3_r;
  assign bank_open = open_r;
  assign power_down = pd_r;
  assign self_refresh = sr_r;
  assign refresh_count = refc_r;
endmodule // scbi_device

// [rtl/scbi_fifo.sv]
`timescale 1ns/1ps
// read data queue between the pins and software
module scbi_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("scbi_fifo: depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  // one extra pointer bit tells full from empty
  assign in_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (ce) begin
      if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
      if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
    end
  end
  // storage
  always_ff @(posedge pclk) begin
    if (ce && in_valid && in_ready) mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule // scbi_fifo

// [rtl/scbi_if.sv]
`timescale 1ns/1ps
// pins between the memory controller and the memory
interface scbi_if (
  input wire logic pclk
);
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic bank_select_bit0, bank_select_bit1;
  logic [11:0] addr;
  logic address_bit_ten_autoprecharge;
  logic low_byte_mask, high_byte_mask;
  logic [15:0] dev_dq_o, ctl_dq_o, data_io_bus;
  logic dev_dq_oe, ctl_dq_oe;
  // the memory wins a clash so a bad turnaround shows up as wrong data
  assign data_io_bus = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 16'h0000);
  assign address_bit_ten_autoprecharge = addr[10];
  modport dev (
    input pclk, cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1,
    input addr, address_bit_ten_autoprecharge, low_byte_mask, high_byte_mask, data_io_bus,
    output dev_dq_o, dev_dq_oe
  );
  modport ctl (
    input pclk, data_io_bus,
    output cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1,
    output addr, low_byte_mask, high_byte_mask, ctl_dq_o, ctl_dq_oe
  );
endinterface // scbi_if

// [rtl/scbi_pkg.sv]
// What this block does
// [RL1] Sample all pins on rising clock edge
// [RL2] Each edge advances burst address, output data
// [RL3] Four banks of 2M sixteen-bit words
// [RL4] Controller activates row before read/write
// [RL5] Burst length 1, 2, 4, 8, page
// [RL6] Burst order linear or interleaved
// [RL7] Read latency 2 or 3; controller samples
// [RL8] Burst stop ends running burst
// [RL9] Auto precharge closes row after burst
// [RL10] Auto/self refresh; 4096 per 64 ms
// [RL11] Clock enable low freezes from next cycle
// [RL12] Low power entry only with banks idle
// [RL13] Clock enable watched live while low power
// [RL14] Inputs ignored during low power modes
// [RL15] Bank select picks the command's bank
// [RL16] Row on twelve bits, column nine, bit ten
// [RL17] Chip select high masks every command
// [RL18] Row strobe low: write enable picks open/precharge
// [RL19] Bank select bit one is the MSB
package scbi_pkg;
  localparam int BANKS = 4;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int AP_BIT = 10;
  // command code is {row strobe, column strobe, write enable}, all low-true
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // mode word layout
  localparam int MODE_W = 7;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RST = 7'h22;
  // refresh pacing
  localparam int REF_COUNT = 4096;
  localparam int REF_WINDOW_MS = 64;
  localparam int CLK_PERIOD_NS = 50;
  localparam int REF_INT_NS = REF_WINDOW_MS * 1000000 / REF_COUNT;
  localparam int REF_INT_CYC = REF_INT_NS / CLK_PERIOD_NS;
  localparam int REF_TMR_W = $clog2(REF_INT_CYC + 1);
  // controller registers
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_MODE = 12'h008;
  localparam logic [11:0] REG_WDATA = 12'h00C;
  localparam logic [11:0] REG_STAT = 12'h010;
  localparam logic [11:0] REG_RDATA = 12'h014;
  localparam logic [11:0] REG_PWR = 12'h018;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_AP = 2;
  localparam int ADR_COL_LSB = 0;
  localparam int ADR_ROW_LSB = 9;
  localparam int ADR_BANK_LSB = 21;
  localparam int ADR_W = 23;
  localparam int PWR_PD = 0;
  localparam int PWR_SR = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RDV = 1;
  localparam int STAT_LOW = 2;
endpackage

// [tb/scbi_props.sv]
`timescale 1ns/1ps
// watches the pins between the controller and the memory
module scbi_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [11:0] addr,
  // data enables
  input wire logic dev_dq_oe,
  input wire logic ctl_dq_oe
);
  import scbi_pkg::*;
  logic [2:0] cmd;
  logic [1:0] bank;
  logic rd_cmd;
  logic wr_cmd;
  logic [3:0] open_r;
  logic [9:0] ref_gap_r;
  assign cmd = {ras_n, cas_n, we_n};
  assign bank = {bank_select_bit1, bank_select_bit0};
  assign rd_cmd = !cs_n && cmd == CMD_RD;
  assign wr_cmd = !cs_n && cmd == CMD_WR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // rows seen opened on the pins; closing early on autoprecharge loosens the sleep check but tightens the open-bank check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_r <= 4'h0;
    end else if (!cs_n && cmd == CMD_ACT) begin
      open_r <= open_r | (4'h1 << bank);
    end else if (!cs_n && cmd == CMD_PRE) begin
      open_r <= addr[10] ? 4'h0 : open_r & ~(4'h1 << bank);
    end else if ((rd_cmd || wr_cmd) && addr[10]) begin
      open_r <= open_r & ~(4'h1 << bank);
    end
  end
  // cycles since the last refresh while awake; long bursts may delay one, hence the slack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_gap_r <= 10'h000;
    end else if (!cke || (!cs_n && cmd == CMD_REF)) begin
      ref_gap_r <= 10'h000;
    end else if (ref_gap_r != 10'h3FF) begin
      ref_gap_r <= ref_gap_r + 10'h001;
    end
  end
  a_rd_latency: assert property ($rose(dev_dq_oe) |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
    else $error("read data not two or three cycles after a read");
  a_no_clash: assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data bus");
  a_chip_sel: assert property (cs_n == 1'b0)
    else $error("chip select left high");
  a_rd_open_bank: assert property ((rd_cmd || wr_cmd) |-> open_r[bank])
    else $error("column command to a closed bank");
  a_sleep_idle: assert property ($fell(cke) |-> open_r == 4'h0 && !dev_dq_oe)
    else $error("clock enable dropped with a bank open");
  a_wr_data_start: assert property ($rose(ctl_dq_oe) |-> wr_cmd)
    else $error("write data driven without a write");
  a_freeze_out: assert property (!cke |-> ##2 $stable(dev_dq_oe))
    else $error("device output moved while frozen");
  a_ref_spacing: assert property (ref_gap_r < 10'h2BC)
    else $error("refresh overdue");
  c_read: cover property (rd_cmd);
  c_write: cover property (wr_cmd);
  c_sleep: cover property ($fell(cke));
endmodule // scbi_props

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CHK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", name, exp, got); end end
module testbench;
  import scbi_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_val;
  logic pready, pslverr, power_down, self_refresh;
  logic [3:0] bank_open;
  logic [15:0] refresh_count;
  logic [33:0] note_q[$];
  logic [15:0] mem_m[int];
  int err_count = 0;
  int tests_run = 0;
  always #25 pclk = ~pclk;
  scbi_if mem_if (.pclk(pclk));
  scbi_ctrl scbi_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem(mem_if.ctl));
  // a small array keeps the memory cheap; columns still wrap at sixteen for page bursts
  scbi_device #(.ROW_USED(4), .COL_USED(4)) scbi_device_inst (.mem(mem_if.dev), .presetn(presetn),
    .bank_open(bank_open), .power_down(power_down), .self_refresh(self_refresh), .refresh_count(refresh_count));
  scbi_props scbi_props_inst (.pclk(pclk), .presetn(presetn), .cke(mem_if.cke), .cs_n(mem_if.cs_n),
    .ras_n(mem_if.ras_n), .cas_n(mem_if.cas_n), .we_n(mem_if.we_n), .bank_select_bit0(mem_if.bank_select_bit0),
    .bank_select_bit1(mem_if.bank_select_bit1), .addr(mem_if.addr), .dev_dq_oe(mem_if.dev_dq_oe),
    .ctl_dq_oe(mem_if.ctl_dq_oe));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // each completed read takes the oldest note; polls leave notes that are not compared
  always @(posedge pclk) begin
    logic [33:0] n;
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (note_q.size() == 0) `CHK("note queue", 1'b1, 1'b0)
      else begin
        n = note_q.pop_front();
        if (n[33]) `CHK("read word", n[32:0], {pslverr, prdata})
      end
    end
  end
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic chk,
                     input logic [32:0] exp);
    int n;
    if (!w) note_q.push_back({chk, exp});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd_val = prdata;
    if (n == 50) begin
      `CHK("pready", 1'b1, 1'b0)
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // poll a status bit; a stuck flag ends the run
  task automatic wait_stat(input int bitn, input logic val);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(REG_STAT, 1'b0, 32'h0, 1'b0, 33'h0);
      if (rd_val[bitn] === val) break;
    end
    if (n == 300) begin
      `CHK("status wait", val, ~val)
      tally_and_finish();
    end
  endtask
  function automatic logic [3:0] baddr(input logic [3:0] s, input int k, input int len, input logic il);
    logic [3:0] m;
    m = 4'(len - 1);
    return (s & ~m) | ((il ? (s ^ 4'(k)) : (s + 4'(k))) & m);
  endfunction
  initial begin
    logic [1:0] bk;
    logic [3:0] row, col, rcol;
    logic [15:0] wd, rc0;
    logic ap, il;
    logic [2:0] cl;
    int len, bl, pdn;
    void'($urandom(32'hE2AE));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(REG_MODE, 1'b0, 32'h0, 1'b1, {1'b0, 25'h0, MODE_RST});
    apb(12'h01C, 1'b0, 32'h0, 1'b1, {1'b1, 32'h0});
    // every burst length, both orders except page bursts, which run linear only, both latencies; reads of 2, 4 and 8 word bursts start one column off
    for (int c = 0; c < 20; c++) begin
      bl = (c % 5 == 4) ? 7 : c % 5;
      il = (bl != 7) && ((c / 5) % 2 == 1);
      cl = (c < 10) ? 3'h2 : CL_3;
      len = (bl == 7) ? 16 : (1 << bl);
      bk = 2'($urandom);
      row = 4'($urandom);
      col = 4'($urandom);
      wd = 16'($urandom);
      ap = (bl != 7) && ($urandom_range(1) == 1);
      apb(REG_MODE, 1'b1, 32'({cl, il, 3'(bl)}), 1'b0, 33'h0);
      wait_stat(STAT_BUSY, 1'b0);
      apb(REG_ADDR, 1'b1, 32'({bk, 8'h0, row, 5'h0, col}), 1'b0, 33'h0);
      apb(REG_WDATA, 1'b1, 32'(wd), 1'b0, 33'h0);
      apb(REG_CTRL, 1'b1, 32'({ap, 2'h3}), 1'b0, 33'h0);
      wait_stat(STAT_BUSY, 1'b0);
      `CHK("bank open", 4'h0, bank_open)
      for (int k = 0; k < len; k++) mem_m[{bk, row, baddr(col, k, len, il)}] = wd + 16'(k);
      rcol = (len > 1 && bl != 7) ? col ^ 4'h1 : col;
      apb(REG_ADDR, 1'b1, 32'({bk, 8'h0, row, 5'h0, rcol}), 1'b0, 33'h0);
      apb(REG_CTRL, 1'b1, 32'({ap, 2'h1}), 1'b0, 33'h0);
      wait_stat(STAT_RDV, 1'b1);
      for (int k = 0; k < len; k++)
        apb(REG_RDATA, 1'b0, 32'h0, 1'b1, {17'h0, mem_m[{bk, row, baddr(rcol, k, len, il)}]});
    end
    // power down, then self refresh, each entered from idle and left again
    apb(REG_PWR, 1'b1, 32'h1, 1'b0, 33'h0);
    wait_stat(STAT_LOW, 1'b1);
    // a due refresh may wake it briefly, so count cycles asleep instead of one sample
    pdn = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      pdn += int'(power_down);
    end
    `CHK("power down", 1'b1, 1'(pdn > 0))
    apb(REG_PWR, 1'b1, 32'h0, 1'b0, 33'h0);
    wait_stat(STAT_LOW, 1'b0);
    rc0 = refresh_count;
    apb(REG_PWR, 1'b1, 32'h2, 1'b0, 33'h0);
    wait_stat(STAT_LOW, 1'b1);
    repeat (700) @(posedge pclk);
    `CHK("self refresh count", 1'b1, 1'((refresh_count - rc0) >= 16'h0002))
    `CHK("self refresh", 1'b1, self_refresh)
    apb(REG_PWR, 1'b1, 32'h0, 1'b0, 33'h0);
    wait_stat(STAT_LOW, 1'b0);
    tally_and_finish();
  end
endmodule // testbench
